// ---- core/tec_regs.svh ----
// Register map, field positions, reset values and timing counts of the
// 16-bit timer/event counter.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TEC_OFF_COUNT 8'h00
`define TEC_OFF_FIRST 8'h04
`define TEC_OFF_SECOND 8'h08
`define TEC_OFF_MODE 8'h0c
`define TEC_OFF_CRC 8'h10
`define TEC_OFF_PRM 8'h14
`define TEC_OFF_TOC 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TEC_MODE_OVF_BIT 0
`define TEC_MODE_SEL_LO 2
`define TEC_MODE_SEL_HI 3
`define TEC_CRC_FIRST_ROLE 0
`define TEC_CRC_FIRST_TRIG 1
`define TEC_CRC_SECOND_ROLE 2
`define TEC_PRM_PRIM_LO 0
`define TEC_PRM_PRIM_HI 1
`define TEC_PRM_SEC_LO 2
`define TEC_PRM_SEC_HI 3
`define TEC_PRM_DIV_LO 4
`define TEC_PRM_DIV_HI 5
`define TEC_TOC_ENABLE_BIT 0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define TEC_RST_COUNT 16'h0000
`define TEC_RST_CAP_CMP 16'h0000
`define TEC_RST_CTRL 8'h00
`define TEC_COUNT_MAX 16'hffff
`define TEC_CAPTURE_MIN_COUNT_CLOCKS 2

`endif

// ---- core/tec_pkg.sv ----
// Types shared by the timer/event counter files.
// Assumes nothing beyond the register header.
package tec_pkg;

   // -------------------------------------------------------------------
   // Mode select and edge select encodings
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      TEC_MODE_STOP,
      TEC_MODE_FREE,
      TEC_MODE_EDGE_CLEAR,
      TEC_MODE_MATCH_CLEAR
   } tec_mode_t;

   typedef enum logic [1:0] {
      TEC_EDGE_FALL,
      TEC_EDGE_RISE,
      TEC_EDGE_NONE,
      TEC_EDGE_BOTH
   } tec_edge_t;

   typedef struct packed {
      logic prev;
      logic seen;
   } tec_edge_state_t;

endpackage : tec_pkg

// ---- core/tec_edge_detect.sv ----
// Rise and fall detector for one pin input.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/10ps

module tec_edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);

   tec_pkg::tec_edge_state_t st;
   tec_pkg::tec_edge_state_t next_st;

   // ----------------------------------------------------------------
   // Edge logic
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.prev = pin;
      next_st.seen = 1'b1;
      // No edge is reported before the first real sample after reset
      rise = st.seen && pin && !st.prev;
      fall = st.seen && !pin && st.prev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : tec_edge_detect

// ---- core/tec_timer.sv ----
// 16-bit timer/event counter with two capture/compare registers,
// reached over APB.
// Assumes pin inputs synchronous to pclk and a single clock domain.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tec_regs.svh"

// What this block does
// [R1] Count up on each enabled count tick
// [R2] Count read freezes ticks for coherent snapshot
// [R3] Counter cleared on reset, stop, edge, match
// [R4] Control bit 0 picks first register role
// [R5] First compare match raises first interrupt
// [R6] Primary edge encoding; drives second capture
// [R7] First captures opposite primary edge; both: none
// [R8] Secondary edge encoding drives first capture
// [R9] Control bit 2 picks second register role
// [R10] Second compare match raises second interrupt
// [R11] Capture/compare registers written as whole words
// [R12] First zero value matches after overflow
// [R13] Second zero value matches after overflow
// [R14] Lowered compare counts through overflow first
// [R15] Software restarts timer after lowering compare
// [R16] Shared pin is input or output, not both
// [R17] Nonzero mode starts counter, zero stops
// [R18] Trigger select: secondary edge or inverted primary
// [R19] Capture pulses exceed two count clocks
// [R20] Capture loads current count into register
module tec_timer #(
   parameter int COUNT_W = 16,
   parameter int DIV_W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_pin_in,
   output logic timer_pin_out,
   output logic timer_pin_oe,
   input wire logic secondary_edge_input,
   output logic first_match_irq,
   output logic second_match_irq
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (COUNT_W != 16) begin : g_bad_width
      $error("tec_timer: COUNT_W must be 16");
   end
   if (DIV_W < 3 || DIV_W > 8) begin : g_bad_div
      $error("tec_timer: DIV_W must lie in 3..8");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] count_value;
      logic [15:0] first_cap_cmp;
      logic [15:0] second_cap_cmp;
      logic [DIV_W-1:0] div;
      logic tick_pend;
      logic ovf;
      logic [1:0] mode_select;
      logic [2:0] cap_cmp_control;
      logic [5:0] prescaler_edge_config;
      logic output_control;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq1;
      logic irq2;
      logic pin_out;
      logic pin_oe;
   } tec_state_t;

   tec_state_t st;
   tec_state_t next_st;

   logic prim_rise;
   logic prim_fall;
   logic sec_rise;
   logic sec_fall;

   tec_edge_detect u_prim (
      .pclk(pclk),
      .presetn(presetn),
      .pin(timer_pin_in),
      .rise(prim_rise),
      .fall(prim_fall)
   );

   tec_edge_detect u_sec (
      .pclk(pclk),
      .presetn(presetn),
      .pin(secondary_edge_input),
      .rise(sec_rise),
      .fall(sec_fall)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
      logic hit;
      hit = 1'b0;
      case (tec_pkg::tec_edge_t'(sel))
         tec_pkg::TEC_EDGE_FALL: hit = fall;
         tec_pkg::TEC_EDGE_RISE: hit = rise;
         tec_pkg::TEC_EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   // Opposite phase of a valid edge; both edges map to no capture
   function automatic logic [1:0] opposite_edge(input logic [1:0] sel);
      logic [1:0] opp;
      opp = tec_pkg::TEC_EDGE_NONE;
      case (tec_pkg::tec_edge_t'(sel))
         tec_pkg::TEC_EDGE_FALL: opp = tec_pkg::TEC_EDGE_RISE;
         tec_pkg::TEC_EDGE_RISE: opp = tec_pkg::TEC_EDGE_FALL;
         default: opp = tec_pkg::TEC_EDGE_NONE;
      endcase
      return opp;
   endfunction : opposite_edge

   function automatic logic mapped(input logic [7:0] addr);
      return addr == `TEC_OFF_COUNT || addr == `TEC_OFF_FIRST ||
         addr == `TEC_OFF_SECOND || addr == `TEC_OFF_MODE ||
         addr == `TEC_OFF_CRC || addr == `TEC_OFF_PRM ||
         addr == `TEC_OFF_TOC;
   endfunction : mapped

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   tec_pkg::tec_mode_t mode;
   logic run;
   logic hold;
   logic div_wrap;
   logic tick;
   logic [15:0] inc;
   logic prim_valid;
   logic prim_inverse;
   logic sec_valid;
   logic match1;
   logic match2;
   logic setup;
   logic wr;
   logic [DIV_W-1:0] div_mask;

   always_comb begin
      next_st = st;
      mode = tec_pkg::tec_mode_t'(st.mode_select);
      run = mode != tec_pkg::TEC_MODE_STOP;
      setup = psel && !penable;
      wr = psel && penable && st.pready && pwrite && mapped(paddr);
      // A count read holds off ticks through setup and access
      hold = psel && !pwrite && paddr == `TEC_OFF_COUNT; // R2
      div_mask = DIV_W'((1 << st.prescaler_edge_config[
         `TEC_PRM_DIV_HI:`TEC_PRM_DIV_LO]) - 1);
      next_st.div = st.div + DIV_W'(1);
      div_wrap = (st.div & div_mask) == div_mask;
      // One held tick is deferred in tick_pend; further ticks during the hold are lost
      tick = run && (div_wrap || st.tick_pend) && !hold; // R2
      if (run && div_wrap && hold) begin
         next_st.tick_pend = 1'b1;
      end else if (tick || !run) begin
         next_st.tick_pend = 1'b0;
      end
      inc = st.count_value + 16'h0001;
      // Primary edges only count while the shared pin is an input
      prim_valid = !st.pin_oe && edge_hit(
         st.prescaler_edge_config[`TEC_PRM_PRIM_HI:`TEC_PRM_PRIM_LO],
         prim_rise, prim_fall); // R6 R16
      prim_inverse = !st.pin_oe && edge_hit(opposite_edge(
         st.prescaler_edge_config[`TEC_PRM_PRIM_HI:`TEC_PRM_PRIM_LO]),
         prim_rise, prim_fall); // R7
      sec_valid = edge_hit(
         st.prescaler_edge_config[`TEC_PRM_SEC_HI:`TEC_PRM_SEC_LO],
         sec_rise, sec_fall); // R8
      // Match on the value being entered, so zero fires after wrap
      match1 = tick && !st.cap_cmp_control[`TEC_CRC_FIRST_ROLE] &&
         inc == st.first_cap_cmp; // R5 R12 R14
      match2 = tick && !st.cap_cmp_control[`TEC_CRC_SECOND_ROLE] &&
         inc == st.second_cap_cmp; // R10 R13

      // Bus writes; hardware events below win the same cycle
      if (wr) begin
         case (paddr)
            `TEC_OFF_FIRST: next_st.first_cap_cmp = pwdata[15:0]; // R11
            `TEC_OFF_SECOND: next_st.second_cap_cmp = pwdata[15:0]; // R11
            `TEC_OFF_MODE: begin
               next_st.mode_select =
                  pwdata[`TEC_MODE_SEL_HI:`TEC_MODE_SEL_LO]; // R17
               next_st.ovf = pwdata[`TEC_MODE_OVF_BIT];
            end
            `TEC_OFF_CRC: next_st.cap_cmp_control = pwdata[2:0];
            `TEC_OFF_PRM: next_st.prescaler_edge_config = pwdata[5:0];
            `TEC_OFF_TOC: begin
               next_st.output_control = pwdata[`TEC_TOC_ENABLE_BIT];
            end
            default: ;
         endcase
      end

      // Counter
      if (!run) begin
         next_st.count_value = `TEC_RST_COUNT; // R3
      end else if (mode == tec_pkg::TEC_MODE_EDGE_CLEAR && prim_valid) begin
         next_st.count_value = `TEC_RST_COUNT; // R3
      end else if (tick) begin
         if (mode == tec_pkg::TEC_MODE_MATCH_CLEAR &&
             !st.cap_cmp_control[`TEC_CRC_FIRST_ROLE] &&
             inc == st.first_cap_cmp) begin
            next_st.count_value = `TEC_RST_COUNT; // R3
         end else begin
            next_st.count_value = inc; // R1 R14
         end
         if (st.count_value == `TEC_COUNT_MAX) begin
            next_st.ovf = 1'b1;
         end
      end

      // Captures take the count as it stands
      if (run && st.cap_cmp_control[`TEC_CRC_FIRST_ROLE]) begin // R4
         if (st.cap_cmp_control[`TEC_CRC_FIRST_TRIG] ? prim_inverse
                                                      : sec_valid) begin
            next_st.first_cap_cmp = st.count_value; // R18 R20
         end
      end
      if (run && st.cap_cmp_control[`TEC_CRC_SECOND_ROLE] &&
          prim_valid) begin // R9
         next_st.second_cap_cmp = st.count_value; // R20
      end

      next_st.irq1 = match1; // R5
      next_st.irq2 = match2; // R10

      // Shared pin: driven only while output use is selected
      next_st.pin_oe = st.output_control; // R16
      if (!st.output_control) begin
         next_st.pin_out = 1'b0;
      end else if (match1 || match2) begin
         next_st.pin_out = !st.pin_out;
      end

      // APB answer is prepared in setup, so access never waits
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      if (setup) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !mapped(paddr);
         next_st.prdata = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               `TEC_OFF_COUNT: next_st.prdata = {16'h0000, st.count_value};
               `TEC_OFF_FIRST: next_st.prdata = {16'h0000, st.first_cap_cmp};
               `TEC_OFF_SECOND: begin
                  next_st.prdata = {16'h0000, st.second_cap_cmp};
               end
               `TEC_OFF_MODE: begin
                  next_st.prdata = {28'h0000000, st.mode_select, 1'b0, st.ovf};
               end
               `TEC_OFF_CRC: next_st.prdata = {29'h0, st.cap_cmp_control};
               `TEC_OFF_PRM: begin
                  next_st.prdata = {26'h0, st.prescaler_edge_config};
               end
               `TEC_OFF_TOC: next_st.prdata = {31'h0, st.output_control};
               default: next_st.prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.count_value <= `TEC_RST_COUNT; // R3
         st.first_cap_cmp <= `TEC_RST_CAP_CMP;
         st.second_cap_cmp <= `TEC_RST_CAP_CMP;
         st.mode_select <= 2'(`TEC_RST_CTRL);
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign timer_pin_out = st.pin_out;
   assign timer_pin_oe = st.pin_oe;
   assign first_match_irq = st.irq1;
   assign second_match_irq = st.irq2;

endmodule : tec_timer

// ---- testbench/tec_timer_assertions.sv ----
// Checker for the timer's bus answers, match pin and output enable.
// Assumes it is bound to tec_timer and sees only its ports.
`timescale 1ns/10ps
module tec_timer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_pin_out,
   input wire logic timer_pin_oe,
   input wire logic first_match_irq,
   input wire logic second_match_irq
);
   // -------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property
      (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
   a_read_upper_zero: assert property
      (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_pin_follows_match: assert property
      ((first_match_irq ^ second_match_irq) && timer_pin_oe |->
       timer_pin_out != $past(timer_pin_out))
      else $error("pin did not toggle on match");
   a_oe_by_write: assert property
      ($changed(timer_pin_oe) |->
       $past(pready && pwrite && paddr == 8'h18, 2))
      else $error("output enable moved without write");
endmodule : tec_timer_chk

bind tec_timer tec_timer_chk u_tec_timer_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
   .first_match_irq(first_match_irq), .second_match_irq(second_match_irq));

// ---- testbench/tec_edge_src.sv ----
// External pulse sources and the shared pin's wire.
// Assumes edges are launched just after rising pclk edges.
`timescale 1ns/10ps
module tec_edge_src (
   input wire logic pclk,
   input wire logic timer_pin_out,
   input wire logic timer_pin_oe,
   output logic timer_pin_in,
   output logic secondary_edge_input
);
   logic prim = 1'b0;
   initial secondary_edge_input = 1'b0;
   // Source yields the pin while the block drives it
   assign timer_pin_in = timer_pin_oe ? timer_pin_out : prim;
   // Hold below 3 could lose a capture
   task automatic set_prim(input logic lvl, input int hold);
      @(posedge pclk);
      prim <= lvl;
      repeat (hold) @(posedge pclk);
   endtask : set_prim
   task automatic set_sec(input logic lvl, input int hold);
      @(posedge pclk);
      secondary_edge_input <= lvl;
      repeat (hold) @(posedge pclk);
   endtask : set_sec
endmodule : tec_edge_src

// ---- testbench/tec_timer_tb.sv ----
// Self-checking bench of the timer: APB master, pulse sources, checks.
// Assumes default parameters and a prescaler of pclk/1, except pclk/2 in the second compare run.
`timescale 1ns/10ps
module tec_timer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, a, b;
   logic pready, pslverr, pin_in, pin_out, pin_oe, sec_in, irq1, irq2, err;
   logic lvl;
   logic [1:0] e;
   int fails = 0;
   int checks_done = 0;
   int seed = 30;
   int cyc = 0;
   int n, p, q;
   initial begin
      forever #25 pclk = ~pclk;
   end
   tec_timer #(.COUNT_W(16), .DIV_W(3)) u_tec_timer (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_pin_in(pin_in), .timer_pin_out(pin_out),
      .timer_pin_oe(pin_oe), .secondary_edge_input(sec_in),
      .first_match_irq(irq1), .second_match_irq(irq2));
   tec_edge_src u_tec_edge_src (.pclk(pclk), .timer_pin_out(pin_out),
      .timer_pin_oe(pin_oe), .timer_pin_in(pin_in),
      .secondary_edge_input(sec_in));
   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_irq(input logic s, input int lim, output int k);
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while ((s ? irq2 : irq1) !== 1'b1 && k < lim);
   endtask : wait_irq
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         complete_run();
      end
   end
   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (i != 1 && i != 2) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, 32'h0);
         end
      end
      apb(1'b1, 8'h00, 32'h1234, rd);
      apb(1'b0, 8'h00, 32'h0, rd);
      check(rd, 32'h0);
      apb(1'b1, 8'h40, 32'h1, rd);
      apb(1'b0, 8'h40, 32'h0, rd);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h1);
      a = $random(seed);
      apb(1'b1, 8'h04, a, rd);
      apb(1'b0, 8'h04, 32'h0, rd);
      check(rd, {16'h0, a[15:0]});
      $display("end of register test");
      p = 20 + {$random(seed)} % 30;
      q = 5 + {$random(seed)} % 30;
      apb(1'b1, 8'h04, p, rd);
      apb(1'b1, 8'h08, p + q, rd);
      apb(1'b1, 8'h0c, 32'h4, rd);
      wait_irq(1'b0, 500, n);
      wait_irq(1'b1, 500, n);
      check(n, q);
      apb(1'b0, 8'h00, 32'h0, rd);
      check(rd, p + q + 2);
      apb(1'b1, 8'h0c, 32'h0, rd);
      apb(1'b0, 8'h00, 32'h0, rd);
      check(rd, 32'h0);
      p = 5 + {$random(seed)} % 20;
      apb(1'b1, 8'h04, p, rd);
      apb(1'b1, 8'h08, 32'hffff, rd);
      apb(1'b1, 8'h14, 32'h10, rd);
      apb(1'b1, 8'h0c, 32'hc, rd);
      wait_irq(1'b0, 500, n);
      wait_irq(1'b0, 500, n);
      check(n, 2 * p);
      apb(1'b1, 8'h0c, 32'h0, rd);
      $display("end of compare test");
      for (int i = 0; i < 3; i++) begin
         e = (i == 2) ? 2'b11 : 2'(i);
         lvl = (e == 2'b00);
         u_tec_edge_src.set_prim(lvl, 3);
         u_tec_edge_src.set_sec(lvl, 3);
         apb(1'b1, 8'h14, {e, e}, rd);
         apb(1'b1, 8'h10, 32'h5, rd);
         apb(1'b1, 8'h0c, 32'h4, rd);
         p = 3 + {$random(seed)} % 10;
         u_tec_edge_src.set_prim(!lvl, p);
         u_tec_edge_src.set_sec(!lvl, 3);
         apb(1'b0, 8'h04, 32'h0, a);
         apb(1'b0, 8'h08, 32'h0, b);
         check(a - b, p + 1);
         apb(1'b1, 8'h0c, 32'h0, rd);
      end
      apb(1'b1, 8'h14, 32'h1, rd);
      // Pin low first, so the next rise is a real valid edge
      u_tec_edge_src.set_prim(1'b0, 3);
      apb(1'b1, 8'h10, 32'h7, rd);
      apb(1'b1, 8'h0c, 32'h4, rd);
      p = 3 + {$random(seed)} % 10;
      u_tec_edge_src.set_prim(1'b1, p);
      u_tec_edge_src.set_prim(1'b0, 3);
      apb(1'b0, 8'h04, 32'h0, a);
      apb(1'b0, 8'h08, 32'h0, b);
      check(a - b, p + 1);
      apb(1'b1, 8'h0c, 32'h0, rd);
      apb(1'b1, 8'h04, 32'h5a5a, rd);
      apb(1'b1, 8'h14, 32'h3, rd);
      apb(1'b1, 8'h0c, 32'h4, rd);
      u_tec_edge_src.set_prim(1'b1, 4);
      apb(1'b0, 8'h04, 32'h0, a);
      check(a, 32'h5a5a);
      apb(1'b1, 8'h18, 32'h1, rd);
      apb(1'b0, 8'h08, 32'h0, b);
      u_tec_edge_src.set_prim(1'b0, 4);
      apb(1'b0, 8'h08, 32'h0, rd);
      check(rd, b);
      check({31'h0, pin_oe}, 32'h1);
      $display("end of capture test");
      apb(1'b1, 8'h0c, 32'h0, rd);
      apb(1'b1, 8'h18, 32'h1, rd);
      apb(1'b1, 8'h10, 32'h0, rd);
      apb(1'b1, 8'h04, 32'h20, rd);
      apb(1'b1, 8'h08, 32'h8000, rd);
      apb(1'b1, 8'h0c, 32'h4, rd);
      wait_irq(1'b0, 500, n);
      check(n, 33);
      check({31'h0, pin_out}, 32'h1);
      // Lowered below the count: next match only after the wrap
      apb(1'b1, 8'h04, 32'h0, rd);
      wait_irq(1'b0, 70000, n);
      check(n >= 65497 && n <= 65505, 1);
      $display("end of overflow test");
      complete_run();
   end
endmodule : tec_timer_tb
